// File: logic/ccp_timebase_select.sv
// timer source selection for ten capture/compare/pwm units
`timescale 1ns/100ps
module ccp_timebase_select
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    // mode fields of the units, unit n at bits 4n+3..4n
    input  wire logic [39:0] unit_mode_field,
    // per unit one-hot timer route, unit n at bits 10n+9..10n
    output logic      [99:0] unit_timer_route,
    // per unit pwm output permitted (valid timer in pwm mode)
    output logic      [9:0]  unit_pwm_enable
);

    // ---- decode helpers ----

    // classify a unit's mode field
    function automatic timebase_select_pkg::unit_class_e classify(input logic [3:0] mode);
        if (mode[3:2] == 2'b11)
            classify = timebase_select_pkg::CLASS_PWM;              // see [RULE_23]
        else if (mode[3:2] == 2'b01)
            classify = timebase_select_pkg::CLASS_CAPTURE;          // see [RULE_23]
        else if (mode[3:2] == 2'b10 || mode == timebase_select_pkg::MODE_CMP_TG)
            classify = timebase_select_pkg::CLASS_COMPARE;          // see [RULE_23]
        else
            classify = timebase_select_pkg::CLASS_OFF;              // off and reserved codes
    endfunction

    // pwm selector to route; code 00 is always timer 2, the other two choices differ per unit group
    function automatic logic [9:0] pwm_route(input logic [1:0] sel,
                                             input logic [9:0] route_b,
                                             input logic [9:0] route_c);
        unique case (sel)
            timebase_select_pkg::SEL_PWM_A: pwm_route = timebase_select_pkg::ROUTE_T2;
            timebase_select_pkg::SEL_PWM_B: pwm_route = route_b;
            timebase_select_pkg::SEL_PWM_C: pwm_route = route_c;
            default:                        pwm_route = timebase_select_pkg::ROUTE_NONE; // see [RULE_24]
        endcase
    endfunction

    // ---- selection registers ----

    logic [7:0] sel_reg0;
    logic [7:0] sel_reg1;
    logic [3:0] sel_reg2;   // upper nibble has no storage, see [RULE_20]

    wire        wr_sel0 = wr_stb && (addr == timebase_select_pkg::ADDR_SEL_0);
    wire        wr_sel1 = wr_stb && (addr == timebase_select_pkg::ADDR_SEL_1);
    wire        wr_sel2 = wr_stb && (addr == timebase_select_pkg::ADDR_SEL_2);

    // software writes; every reset clears the fields
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg0 <= timebase_select_pkg::RESET_SEL;                  // see [RULE_21]
            sel_reg1 <= timebase_select_pkg::RESET_SEL;                  // see [RULE_21]
            sel_reg2 <= timebase_select_pkg::RESET_SEL[3:0];             // see [RULE_21]
        end
        else
        begin
            if (wr_sel0)
                sel_reg0 <= wdata;                                       // see [RULE_21]
            if (wr_sel1)
                sel_reg1 <= wdata;                                       // see [RULE_21]
            if (wr_sel2)
                sel_reg2 <= wdata[3:0];                                  // see [RULE_20]
        end
    end

    // read mux; unmapped offset reads zero
    logic [7:0] next_rdata;
    always_comb
    begin
        unique case (addr)
            timebase_select_pkg::ADDR_SEL_0: next_rdata = sel_reg0;      // see [RULE_21]
            timebase_select_pkg::ADDR_SEL_1: next_rdata = sel_reg1;      // see [RULE_21]
            timebase_select_pkg::ADDR_SEL_2: next_rdata = {4'h0, sel_reg2} &
                                                         timebase_select_pkg::SEL_2_MASK; // see [RULE_20]
            default:                         next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd_stb)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    // ---- per unit routing ----

    // all selector fields gathered, unit n at bits 2n+1..2n
    wire [19:0] sel_all = {sel_reg2, sel_reg1, sel_reg0};

    // per-unit alternatives: units 1-4 use timers 3/4/6, 5-7 use 5/6/8, 8-10 use 5/8/10
    logic [99:0] next_route;
    logic [9:0]  next_pwm_en;

    genvar u;
    generate
        for (u = 0; u < 10; u = u + 1)
        begin : g_unit
            wire [1:0] sel = sel_all[2*u +: 2];
            wire timebase_select_pkg::unit_class_e cls = classify(unit_mode_field[4*u +: 4]);
            // capture/compare second timer: timer 3 for units 1-4, timer 5 after
            wire [9:0] cc_alt  = (u < 4) ? timebase_select_pkg::ROUTE_T3
                                         : timebase_select_pkg::ROUTE_T5;
            // pwm choices for codes 01 and 10
            wire [9:0] pwm_b   = (u < 4) ? timebase_select_pkg::ROUTE_T4 :
                                 (u < 7) ? timebase_select_pkg::ROUTE_T6 :
                                           timebase_select_pkg::ROUTE_T8;
            wire [9:0] pwm_c   = (u < 4) ? timebase_select_pkg::ROUTE_T6 :
                                 (u < 7) ? timebase_select_pkg::ROUTE_T8 :
                                           timebase_select_pkg::ROUTE_T10;
            // high bit ignored outside pwm
            wire [9:0] cc_rt   = sel[0] ? cc_alt : timebase_select_pkg::ROUTE_T1;
            // units 1-4 pwm, see [RULE_01] [RULE_03] [RULE_05] [RULE_07]
            // units 5-7 pwm, see [RULE_11] [RULE_13] [RULE_15]
            // units 8-10 pwm, see [RULE_09] [RULE_17] [RULE_19]
            wire [9:0] pwm_rt  = pwm_route(sel, pwm_b, pwm_c);
            // capture/compare units 1-4, see [RULE_02] [RULE_04] [RULE_06] [RULE_22]
            // capture/compare units 5-8, see [RULE_08] [RULE_10] [RULE_12] [RULE_14]
            // capture/compare units 9-10, see [RULE_16] [RULE_18]
            wire is_cc  = (cls == timebase_select_pkg::CLASS_CAPTURE) ||
                          (cls == timebase_select_pkg::CLASS_COMPARE);
            wire is_pwm = (cls == timebase_select_pkg::CLASS_PWM);
            assign next_route[10*u +: 10] = is_cc  ? cc_rt :
                                            is_pwm ? pwm_rt :
                                            timebase_select_pkg::ROUTE_NONE; // see [RULE_23]
            // reserved code keeps the pwm output quiet
            assign next_pwm_en[u] = is_pwm && (sel != 2'b11);           // see [RULE_24]
        end
    endgenerate

    // registered outputs; one cycle latency after a mode change, two cycles after a write strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unit_timer_route <= '0;
            unit_pwm_enable  <= '0;
        end
        else
        begin
            unit_timer_route <= next_route;
            unit_pwm_enable  <= next_pwm_en;
        end
    end

endmodule

// File: logic/timebase_select_pkg.sv
// constants for the ten-unit capture/compare/pwm timebase selection block
//
// Function
// [RULE_01] unit 4 pwm: 00 t2, 01 t4, 10 t6
// [RULE_02] unit 3 capture/compare: low bit t1/t3
// [RULE_03] unit 3 pwm: 00 t2, 01 t4, 10 t6
// [RULE_04] unit 2 capture/compare: low bit t1/t3
// [RULE_05] unit 2 pwm: 00 t2, 01 t4, 10 t6
// [RULE_06] unit 1 capture/compare: low bit t1/t3
// [RULE_07] unit 1 pwm: 00 t2, 01 t4, 10 t6
// [RULE_08] unit 8 capture/compare: low bit t1/t5
// [RULE_09] unit 8 pwm: 00 t2, 01 t8, 10 t10
// [RULE_10] unit 7 capture/compare: low bit t1/t5
// [RULE_11] unit 7 pwm: 00 t2, 01 t6, 10 t8
// [RULE_12] unit 6 capture/compare: low bit t1/t5
// [RULE_13] unit 6 pwm: 00 t2, 01 t6, 10 t8
// [RULE_14] unit 5 capture/compare: low bit t1/t5
// [RULE_15] unit 5 pwm: 00 t2, 01 t6, 10 t8
// [RULE_16] unit 10 capture/compare: low bit t1/t5
// [RULE_17] unit 10 pwm: 00 t2, 01 t8, 10 t10
// [RULE_18] unit 9 capture/compare: low bit t1/t5
// [RULE_19] unit 9 pwm: 00 t2, 01 t8, 10 t10
// [RULE_20] register 2 upper nibble unstored, reads zero
// [RULE_21] selectors read/write, cleared by every reset
// [RULE_22] unit 4 capture/compare: low bit t1/t3
// [RULE_23] mode field picks off, capture, compare, pwm
// [RULE_24] reserved pwm code routes no timer
package timebase_select_pkg;

    localparam int unsigned NUM_UNITS  = 10;
    localparam int unsigned ADDR_W     = 2;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned SEL_W      = 2;
    localparam int unsigned MODE_W     = 4;

    // register offsets on the plain register port
    localparam logic [1:0] ADDR_SEL_0  = 2'h0;
    localparam logic [1:0] ADDR_SEL_1  = 2'h1;
    localparam logic [1:0] ADDR_SEL_2  = 2'h2;

    localparam logic [7:0] RESET_SEL   = 8'h00;
    localparam logic [7:0] SEL_2_MASK  = 8'h0f;

    // selector codes
    localparam logic [1:0] SEL_PWM_A   = 2'h0;
    localparam logic [1:0] SEL_PWM_B   = 2'h1;
    localparam logic [1:0] SEL_PWM_C   = 2'h2;

    // mode field codes
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] MODE_CMP_TG = 4'h2;

    // one-hot timer route codes: bit n set means timer n+1
    localparam int unsigned ROUTE_W    = 10;
    localparam logic [9:0] ROUTE_NONE  = 10'h000;
    localparam logic [9:0] ROUTE_T1    = 10'h001;
    localparam logic [9:0] ROUTE_T2    = 10'h002;
    localparam logic [9:0] ROUTE_T3    = 10'h004;
    localparam logic [9:0] ROUTE_T4    = 10'h008;
    localparam logic [9:0] ROUTE_T5    = 10'h010;
    localparam logic [9:0] ROUTE_T6    = 10'h020;
    localparam logic [9:0] ROUTE_T8    = 10'h080;
    localparam logic [9:0] ROUTE_T10   = 10'h200;

    // decoded operating class of a unit, one-hot
    typedef enum logic [3:0] {
        CLASS_OFF     = 4'b0001,
        CLASS_CAPTURE = 4'b0010,
        CLASS_COMPARE = 4'b0100,
        CLASS_PWM     = 4'b1000
    } unit_class_e;

endpackage

// File: verification/ccp_timebase_select_properties.sv
// port-level checks for the timebase selection block
`timescale 1ns/100ps
module ccp_timebase_select_checker
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [1:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [7:0]  rdata,
    // unit side
    input wire logic [39:0] unit_mode_field,
    input wire logic [99:0] unit_timer_route,
    input wire logic [9:0]  unit_pwm_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a write straight followed by a read of the same register
    sequence wr_then_rd;
        wr_stb && addr == 2'h0 ##1 rd_stb && addr == 2'h0;
    endsequence
    rd_idle_zero_a: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("rdata not zero outside a read");
    readback_match_a: assert property (wr_then_rd |=> rdata == $past(wdata, 2))
        else $error("readback differs from written value");
    unmapped_read_a: assert property (rd_stb && addr == 2'h3 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    upper_nibble_a: assert property (rd_stb && addr == 2'h2 |=> rdata[7:4] == 4'h0)
        else $error("upper nibble of register 2 not zero");
    off_no_route_a: assert property (unit_mode_field[3:0] == 4'h0
        |=> unit_timer_route[9:0] == 10'h000 && !unit_pwm_enable[0])
        else $error("unit off but routed");
    pwm_route_set_a: assert property (unit_mode_field[3:2] == 2'b11
        |=> unit_timer_route[9:0] inside {10'h000, 10'h002, 10'h008, 10'h020})
        else $error("unit 1 pwm route outside its timers");
    capture_route_set_a: assert property (unit_mode_field[39:38] == 2'b01
        |=> unit_timer_route[99:90] inside {10'h001, 10'h010})
        else $error("unit 10 capture route outside its timers");
    enable_only_pwm_a: assert property (unit_mode_field[3:2] != 2'b11
        |=> !unit_pwm_enable[0])
        else $error("pwm enable outside pwm mode");
    enable_onehot_a: assert property (unit_pwm_enable[0] |-> $onehot(unit_timer_route[9:0]))
        else $error("pwm enable without a single timer");
endmodule

bind ccp_timebase_select ccp_timebase_select_checker u_checker (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .unit_mode_field(unit_mode_field), .unit_timer_route(unit_timer_route),
    .unit_pwm_enable(unit_pwm_enable));

// File: verification/tb_ccp_timebase_select.sv
// self-checking bench for the timebase selection block
`timescale 1ns/100ps
module tb_ccp_timebase_select;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [39:0] unit_mode_field = 40'h0;
    logic [7:0]  rdata;
    logic [99:0] unit_timer_route;
    logic [9:0]  unit_pwm_enable;
    int          mismatches = 0;
    int          checks = 0;
    // off, reserved, compare, capture and pwm codes
    logic [3:0]  modes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hc, 4'hf};

    always #20 sys_clk = ~sys_clk;

    ccp_timebase_select dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .unit_mode_field(unit_mode_field),
        .unit_timer_route(unit_timer_route), .unit_pwm_enable(unit_pwm_enable));

    task automatic chk(input string what, input logic [99:0] seen, input logic [99:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // leaves the strobe high so a read may follow with no gap
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 chk("rdata", {92'h0, rdata}, {92'h0, exp});
    endtask

    task automatic idle();
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    endtask

    // bit 10 is the pwm enable, bits 9:0 the one-hot route
    function automatic logic [10:0] expect_unit(input int u, input logic [3:0] m,
                                                input logic [1:0] s);
        if (m[3:2] == 2'b11 && s != 2'h3)
            return {1'b1, (s == 2'h0) ? 10'h002
                : 10'h001 << (u < 4 ? 2 * s + 1 : u < 7 ? 2 * s + 3 : 2 * s + 5)};
        if (m[3:2] == 2'b01 || m[3:2] == 2'b10 || m == 4'h2)
            return {1'b0, s[0] ? ((u < 4) ? 10'h004 : 10'h010) : 10'h001};
        return 11'h000;
    endfunction

    task automatic reg_access();
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h00);
        wr(2'h0, 8'h5a);
        rd(2'h0, 8'h5a);
        wr(2'h1, 8'ha5);
        rd(2'h1, 8'ha5);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h0f);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        rd(2'h0, 8'h5a);
    endtask

    // neighbouring units get different codes and modes so crossed fields show up
    task automatic route_sweep();
        logic [7:0]  r [3];
        logic [39:0] mv;
        logic [10:0] e;
        for (int k = 0; k < 9; k++)
            for (int p = 0; p < 4; p++)
            begin
                r = '{8'h00, 8'h00, 8'h00};
                for (int u = 0; u < 10; u++)
                begin
                    r[u / 4][2 * (u % 4) +: 2] = 2'(u + p);
                    mv[4 * u +: 4] = modes[(u + k) % 9];
                end
                wr(2'h0, r[0]);
                unit_mode_field <= mv;
                wr(2'h1, r[1]);
                wr(2'h2, r[2]);
                idle();
                repeat (2) @(posedge sys_clk);
                #1;
                for (int u = 0; u < 10; u++)
                begin
                    e = expect_unit(u, mv[4 * u +: 4], 2'(u + p));
                    chk("route", {90'h0, unit_timer_route[10 * u +: 10]}, {90'h0, e[9:0]});
                    chk("pwm_enable", {99'h0, unit_pwm_enable[u]}, {99'h0, e[10]});
                end
            end
    endtask

    task automatic reset_mid();
        wr(2'h0, 8'hff);
        wr(2'h1, 8'hff);
        idle();
        rst_n <= 1'b0;
        #1 chk("route_in_reset", unit_timer_route, 100'h0);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
    endtask

    task automatic close_out();
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_access();
        route_sweep();
        reset_mid();
        close_out();
    end
endmodule
